// file: phg_regs.vh
// Register map, field positions and reset values of the port H block.
// Assumes inclusion by bare name from the port H design files.
`ifndef PHG_REGS_VH
`define PHG_REGS_VH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define PHG_IDX_ALT_FLAGS 6'h1f
`define PHG_IDX_DATA 6'h20
`define PHG_IDX_LEVELS 6'h21
`define PHG_IDX_DIR 6'h22
`define PHG_IDX_DRIVE 6'h23
`define PHG_IDX_PULL 6'h24
`define PHG_IDX_POL 6'h25
`define PHG_IDX_IRQEN 6'h26
`define PHG_IDX_FLAGS 6'h27
`define PHG_IDX_ALT_POL 6'h28
`define PHG_IDX_ALT_IRQEN 6'h29
`define PHG_IDX_ROUTE 6'h2a
`define PHG_IDX_SPI_EN 6'h2b

// ****************************************
// Address layout and reset values
// ****************************************
`define PHG_IDX_MSB 7
`define PHG_IDX_LSB 2
`define PHG_ZERO8 8'h00
`define PHG_RESP_OKAY 2'h0
`define PHG_RESP_SLVERR 2'h2
`define PHG_SERIAL_PERIPH_FIRST_BIT 0
`define PHG_SERIAL_PERIPH_SECOND_BIT 1

`endif

// file: phg_edge_det.v
// Per-pin two-stage synchroniser and polarity-selected edge detector.
// Assumes pins arrive asynchronously to aclk.
`timescale 1ns/1ps
`default_nettype none
module phg_edge_det #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Pin side
	input wire [WIDTH-1:0] pin_in,
	input wire [WIDTH-1:0] polarity,
	// Results
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] edge_hit
);
	reg [WIDTH-1:0] sync1_reg;
	reg [WIDTH-1:0] sync2_reg;
	reg [WIDTH-1:0] prev_reg;
	// Synchroniser chain plus history stage
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= {WIDTH{1'b0}};
			sync2_reg <= {WIDTH{1'b0}};
			prev_reg <= {WIDTH{1'b0}};
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end
	assign level = sync2_reg;
	// Rising edge when polarity is one, falling when zero
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_edge
			assign edge_hit[i] = polarity[i] ? (sync2_reg[i] & ~prev_reg[i]) :
				(~sync2_reg[i] & prev_reg[i]);
		end
	endgenerate
endmodule // phg_edge_det
`default_nettype wire

// file: phg_port.v
// Port H general-purpose port with edge interrupts, plus neighbouring port flags.
// Assumes an AXI4-Lite master on aclk and asynchronous pins and peripheral lines.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "phg_regs.vh"

// Summary of operation
// - An active input edge sets that pin's flag.
// - Writing one clears a flag; zero leaves it; zero means none pending.
// - Interrupt request whenever a set flag has its enable bit one.
// - Polarity zero: falling edge sets flag; pull-up when pulls enabled on input.
// - Polarity one: rising edge sets flag; pull-down when pulls enabled on input.
// - Pull enable activates chosen pull; ignored while the pin is an output.
// - No pull device is enabled after reset.
// - Direction bit zero is input, one is output, unless a peripheral owns it.
// - Data read gives latch where the direction bit is one, pin level for others.
// - Level register always returns pin levels; writes ignored.
// - Reduced-drive bit one gives weak drive; ignored on inputs.
// - Enable bit one passes a pin's flag; zero masks it.
// - An enabled serial peripheral overrides pin direction and output value.
// - Second peripheral owns pins 7..4, first owns 3..0, select-clock-MOSI-MISO order.
// - Routing register only drives the two route outputs; peripheral pin assignment stays fixed.
// - Reset makes all pins high-impedance inputs and clears the data latch.
// - Neighbouring port flags set by its edges and polarity, cleared by writing one.
// - Neighbouring polarity zero picks falling edges, one picks rising.
// - Neighbouring enable register gates its flags onto its request.
module phg_port #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Port H pins
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] pin_out,
	output reg [WIDTH-1:0] pin_oe,
	output reg [WIDTH-1:0] pin_weak_drive,
	output reg [WIDTH-1:0] pin_pull_up,
	output reg [WIDTH-1:0] pin_pull_down,
	// Serial peripheral pin requests, bit order select, clock, MOSI, MISO per half
	input wire [WIDTH-1:0] spi_out,
	input wire [WIDTH-1:0] spi_oe,
	output reg [WIDTH-1:0] spi_in,
	output reg serial_periph_first_route,
	output reg serial_periph_second_route,
	// Neighbouring port pins
	input wire [WIDTH-1:0] alt_pin_in,
	// Interrupt requests
	output reg port_irq,
	output reg alt_port_irq
);
	// ****************************************
	// Registers
	// ****************************************
	reg [WIDTH-1:0] port_data_reg;
	reg [WIDTH-1:0] port_direction_reg;
	reg [WIDTH-1:0] port_drive_strength_reg;
	reg [WIDTH-1:0] port_pull_enable_reg;
	reg [WIDTH-1:0] port_edge_polarity_reg;
	reg [WIDTH-1:0] port_irq_enable_reg;
	reg [WIDTH-1:0] port_edge_flags_reg;
	reg [WIDTH-1:0] alt_port_edge_flags_reg;
	reg [WIDTH-1:0] alt_port_edge_polarity_reg;
	reg [WIDTH-1:0] alt_port_irq_enable_reg;
	reg [1:0] module_routing_select_reg;
	reg [1:0] spi_enable_reg;
	reg [5:0] wr_idx_reg;
	reg [WIDTH-1:0] wr_data_reg;
	reg aw_held_reg;
	reg w_held_reg;
	reg [WIDTH-1:0] spi_in_sync1_reg;
	reg [WIDTH-1:0] spi_in_sync2_reg;
	wire [WIDTH-1:0] port_level;
	wire [WIDTH-1:0] port_edge;
	wire [WIDTH-1:0] alt_level;
	wire [WIDTH-1:0] alt_edge;
	wire [WIDTH-1:0] spi_own;
	wire [WIDTH-1:0] eff_oe;
	wire [WIDTH-1:0] eff_out;
	wire [WIDTH-1:0] port_flags_next;
	wire [WIDTH-1:0] alt_flags_next;
	wire [WIDTH-1:0] port_clear;
	wire [WIDTH-1:0] alt_clear;
	wire wr_fire;
	wire wr_known;
	wire [5:0] rd_idx;
	reg [WIDTH-1:0] rd_value;
	reg rd_known;

	// ****************************************
	// Edge detection on both ports
	// ****************************************
	// Raw pins feed the detectors, which synchronise them
	phg_edge_det #(.WIDTH(WIDTH)) u_port_det (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(pin_in),
		.polarity(port_edge_polarity_reg),
		.level(port_level),
		.edge_hit(port_edge)
	);
	phg_edge_det #(.WIDTH(WIDTH)) u_alt_det (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(alt_pin_in),
		.polarity(alt_port_edge_polarity_reg),
		.level(alt_level),
		.edge_hit(alt_edge)
	);

	// ****************************************
	// Pin ownership
	// ****************************************
	// Each half is owned by its serial peripheral when enabled
	assign spi_own = {{(WIDTH/2){spi_enable_reg[`PHG_SERIAL_PERIPH_SECOND_BIT]}},
		{(WIDTH/2){spi_enable_reg[`PHG_SERIAL_PERIPH_FIRST_BIT]}}};
	assign eff_oe = (spi_own & spi_oe) | (~spi_own & port_direction_reg);
	assign eff_out = (spi_own & spi_out) | (~spi_own & port_data_reg);

	// ****************************************
	// Write channel
	// ****************************************
	assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign wr_known = (wr_idx_reg >= `PHG_IDX_ALT_FLAGS) && (wr_idx_reg <= `PHG_IDX_SPI_EN);
	assign port_clear = (wr_fire && wr_idx_reg == `PHG_IDX_FLAGS) ? wr_data_reg : `PHG_ZERO8;
	assign alt_clear = (wr_fire && wr_idx_reg == `PHG_IDX_ALT_FLAGS) ? wr_data_reg : `PHG_ZERO8;
	// Set wins over a same-cycle clear
	assign port_flags_next = (port_edge_flags_reg & ~port_clear) | port_edge;
	assign alt_flags_next = (alt_port_edge_flags_reg & ~alt_clear) | alt_edge;

	// Address and data capture, then register update and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PHG_RESP_OKAY;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			wr_idx_reg <= 6'h00;
			wr_data_reg <= `PHG_ZERO8;
			port_data_reg <= `PHG_ZERO8;
			port_direction_reg <= `PHG_ZERO8;
			port_drive_strength_reg <= `PHG_ZERO8;
			port_pull_enable_reg <= `PHG_ZERO8;
			port_edge_polarity_reg <= `PHG_ZERO8;
			port_irq_enable_reg <= `PHG_ZERO8;
			alt_port_edge_polarity_reg <= `PHG_ZERO8;
			alt_port_irq_enable_reg <= `PHG_ZERO8;
			module_routing_select_reg <= 2'h0;
			spi_enable_reg <= 2'h0;
		end else begin
			s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				wr_idx_reg <= s_axi_awaddr[`PHG_IDX_MSB:`PHG_IDX_LSB];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wr_data_reg <= s_axi_wstrb[0] ? s_axi_wdata[WIDTH-1:0] : `PHG_ZERO8;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `PHG_RESP_OKAY : `PHG_RESP_SLVERR;
				case (wr_idx_reg)
					`PHG_IDX_DATA: port_data_reg <= wr_data_reg;
					`PHG_IDX_DIR: port_direction_reg <= wr_data_reg;
					`PHG_IDX_DRIVE: port_drive_strength_reg <= wr_data_reg;
					`PHG_IDX_PULL: port_pull_enable_reg <= wr_data_reg;
					`PHG_IDX_POL: port_edge_polarity_reg <= wr_data_reg;
					`PHG_IDX_IRQEN: port_irq_enable_reg <= wr_data_reg;
					`PHG_IDX_ALT_POL: alt_port_edge_polarity_reg <= wr_data_reg;
					`PHG_IDX_ALT_IRQEN: alt_port_irq_enable_reg <= wr_data_reg;
					`PHG_IDX_ROUTE: module_routing_select_reg <= wr_data_reg[1:0];
					`PHG_IDX_SPI_EN: spi_enable_reg <= wr_data_reg[1:0];
					default: ; // Level register writes are ignored
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Sticky edge flags
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_edge_flags_reg <= `PHG_ZERO8;
			alt_port_edge_flags_reg <= `PHG_ZERO8;
		end else begin
			port_edge_flags_reg <= port_flags_next;
			alt_port_edge_flags_reg <= alt_flags_next;
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	assign rd_idx = s_axi_araddr[`PHG_IDX_MSB:`PHG_IDX_LSB];
	// Read mux
	always @* begin
		rd_known = 1'b1;
		case (rd_idx)
			`PHG_IDX_ALT_FLAGS: rd_value = alt_port_edge_flags_reg;
			`PHG_IDX_DATA: rd_value = (port_direction_reg & port_data_reg) |
				(~port_direction_reg & port_level);
			`PHG_IDX_LEVELS: rd_value = port_level;
			`PHG_IDX_DIR: rd_value = port_direction_reg;
			`PHG_IDX_DRIVE: rd_value = port_drive_strength_reg;
			`PHG_IDX_PULL: rd_value = port_pull_enable_reg;
			`PHG_IDX_POL: rd_value = port_edge_polarity_reg;
			`PHG_IDX_IRQEN: rd_value = port_irq_enable_reg;
			`PHG_IDX_FLAGS: rd_value = port_edge_flags_reg;
			`PHG_IDX_ALT_POL: rd_value = alt_port_edge_polarity_reg;
			`PHG_IDX_ALT_IRQEN: rd_value = alt_port_irq_enable_reg;
			`PHG_IDX_ROUTE: rd_value = {6'h00, module_routing_select_reg};
			`PHG_IDX_SPI_EN: rd_value = {6'h00, spi_enable_reg};
			default: begin
				rd_value = `PHG_ZERO8;
				rd_known = 1'b0;
			end
		endcase
	end

	// Address accept and data return
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PHG_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_value};
				s_axi_rresp <= rd_known ? `PHG_RESP_OKAY : `PHG_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Pin drivers and interrupt outputs
	// ****************************************
	// Registered pad controls, requests and peripheral inputs
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= `PHG_ZERO8;
			pin_oe <= `PHG_ZERO8;
			pin_weak_drive <= `PHG_ZERO8;
			pin_pull_up <= `PHG_ZERO8;
			pin_pull_down <= `PHG_ZERO8;
			spi_in_sync1_reg <= `PHG_ZERO8;
			spi_in_sync2_reg <= `PHG_ZERO8;
			spi_in <= `PHG_ZERO8;
			serial_periph_first_route <= 1'b0;
			serial_periph_second_route <= 1'b0;
			port_irq <= 1'b0;
			alt_port_irq <= 1'b0;
		end else begin
			pin_out <= eff_out;
			pin_oe <= eff_oe;
			pin_weak_drive <= port_drive_strength_reg & eff_oe;
			pin_pull_up <= port_pull_enable_reg & ~eff_oe & ~port_edge_polarity_reg;
			pin_pull_down <= port_pull_enable_reg & ~eff_oe & port_edge_polarity_reg;
			spi_in_sync1_reg <= pin_in;
			spi_in_sync2_reg <= spi_in_sync1_reg;
			spi_in <= spi_in_sync2_reg & spi_own;
			serial_periph_first_route <= module_routing_select_reg[`PHG_SERIAL_PERIPH_FIRST_BIT];
			serial_periph_second_route <= module_routing_select_reg[`PHG_SERIAL_PERIPH_SECOND_BIT];
			port_irq <= |(port_flags_next & port_irq_enable_reg);
			alt_port_irq <= |(alt_flags_next & alt_port_irq_enable_reg);
		end
	end
endmodule // phg_port
`default_nettype wire

// file: phg_port_monitor.sv
// Concurrent checks on the port H pins, requests and read channel.
// Assumes binding to phg_port, one aclk domain, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module phg_port_monitor #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH-1:0] alt_pin_in,
	input wire logic [WIDTH-1:0] pin_oe,
	input wire logic [WIDTH-1:0] pin_weak_drive,
	input wire logic [WIDTH-1:0] pin_pull_up,
	input wire logic [WIDTH-1:0] pin_pull_down,
	// Requests and bus
	input wire logic port_irq,
	input wire logic alt_port_irq,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata
);
	// ****
	// Sequences and assertions
	// ****
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence irq_up; $rose(port_irq); endsequence
	sequence alt_up; $rose(alt_port_irq); endsequence
	sequence read_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence wrote; s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2); endsequence
	reset_quiet_a: assert property ($rose(aresetn) |-> (pin_oe | pin_pull_up | pin_pull_down) == '0)
		else $error("pins active after reset");
	pull_on_output_a: assert property (((pin_pull_up | pin_pull_down) & pin_oe) == '0)
		else $error("pull on driven pin");
	pull_pair_a: assert property ((pin_pull_up & pin_pull_down) == '0)
		else $error("pull-up and pull-down together");
	weak_drive_a: assert property ((pin_weak_drive & ~pin_oe) == '0)
		else $error("reduced drive on input pin");
	irq_cause_a: assert property (irq_up |-> $past(pin_in, 3) != $past(pin_in, 4) or wrote)
		else $error("request rose without edge or write");
	alt_irq_cause_a: assert property (alt_up |-> $past(alt_pin_in, 3) != $past(alt_pin_in, 4) or wrote)
		else $error("neighbour request rose without cause");
	read_answer_a: assert property (read_taken |=> s_axi_rvalid)
		else $error("read data late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
endmodule // phg_port_monitor
`default_nettype wire

// file: phg_pin_model.sv
// External circuitry on the port H pins: bench drivers, pulls, floating.
// Assumes the device drive wins over the bench drivers.
`timescale 1ns/1ps
`default_nettype none
module phg_pin_model #(
	parameter WIDTH = 8
) (
	// Clock
	input wire logic aclk,
	// Device side
	input wire logic [WIDTH-1:0] pin_out,
	input wire logic [WIDTH-1:0] pin_oe,
	input wire logic [WIDTH-1:0] pull_up,
	input wire logic [WIDTH-1:0] pull_down,
	// Bench drivers
	input wire logic [WIDTH-1:0] ext_val,
	input wire logic [WIDTH-1:0] ext_en,
	// Resolved levels
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] float_reg = '0;
	// A floating pin wanders every cycle
	always @(posedge aclk) float_reg <= ~float_reg;
	// Device, then bench, then pull devices, then float
	assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
		(~pin_oe & ~ext_en & (pull_up | (~pull_down & float_reg)));
endmodule // phg_pin_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the port H block over AXI4-Lite.
// Assumes phg_port, phg_pin_model and phg_port_monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int WIDTH = 8;
	localparam int LIMIT = 3000;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] pin_in, pin_out, pin_oe, pin_weak_drive, pin_pull_up, pin_pull_down, pv, dv;
	logic [7:0] spi_out, spi_oe, spi_in, alt_pin_in, ext_val, ext_en;
	logic serial_periph_first_route, serial_periph_second_route, port_irq, alt_port_irq;
	logic [33:0] rq[$], bq[$];
	int num_errors, check_count, cyc;
	phg_port #(.WIDTH(WIDTH)) u_phg_port (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_weak_drive(pin_weak_drive),
		.pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .spi_out(spi_out),
		.spi_oe(spi_oe), .spi_in(spi_in), .serial_periph_first_route(serial_periph_first_route),
		.serial_periph_second_route(serial_periph_second_route), .alt_pin_in(alt_pin_in),
		.port_irq(port_irq), .alt_port_irq(alt_port_irq));
	phg_pin_model #(.WIDTH(WIDTH)) u_phg_pin_model (.aclk(aclk), .pin_out(pin_out),
		.pin_oe(pin_oe), .pull_up(pin_pull_up), .pull_down(pin_pull_down), .ext_val(ext_val),
		.ext_en(ext_en), .level(pin_in));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	function automatic logic [33:0] okv(input logic [7:0] v);
		return {26'h0, v};
	endfunction
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write one register; the response is noted for the watcher
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] resp);
		@(posedge aclk);
		bq.push_back({32'h0, resp});
		s_axi_awaddr <= {24'h0, idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// Read one register; the expected answer is noted for the watcher
	task automatic rd(input logic [5:0] idx, input logic [33:0] exp);
		@(posedge aclk);
		rq.push_back(exp);
		s_axi_araddr <= {24'h0, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	task automatic close_out();
		$display("Errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ****
	// Clock, watcher and timeout
	// ****
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, bq.pop_front());
		cyc++;
		if (cyc == LIMIT) begin
			num_errors++;
			close_out();
		end
	end
	// ****
	// Scenarios
	// ****
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, spi_out, spi_oe, alt_pin_in} = '0;
		s_axi_wstrb = 4'hf;
		ext_en = 8'hff;
		seed = xs(32'd46);
		ext_val = seed[7:0];
		pv = seed[7:0];
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		idle(4);
		check(okv(pin_oe | pin_pull_up | pin_pull_down), okv(8'h00));
		rd(6'h20, okv(pv));
		wr(6'h21, ~pv, 2'h0);
		rd(6'h21, okv(pv));
		rd(6'h24, okv(8'h00));
		seed = xs(seed);
		dv = seed[7:0];
		ext_en <= 8'h0f;
		wr(6'h20, dv, 2'h0);
		wr(6'h22, 8'hf0, 2'h0);
		wr(6'h23, 8'hff, 2'h0);
		idle(4);
		check(okv(pin_oe), okv(8'hf0));
		check(okv(pin_weak_drive), okv(8'hf0));
		rd(6'h20, okv({dv[7:4], pv[3:0]}));
		ext_en <= 8'h00;
		wr(6'h24, 8'hff, 2'h0);
		wr(6'h25, 8'h0c, 2'h0);
		idle(4);
		check(okv(pin_pull_up), okv(8'h03));
		check(okv(pin_pull_down), okv(8'h0c));
		rd(6'h21, okv({dv[7:4], 4'h3}));
		ext_val <= 8'hf0;
		ext_en <= 8'hff;
		wr(6'h22, 8'h00, 2'h0);
		wr(6'h24, 8'h00, 2'h0);
		wr(6'h25, 8'h0f, 2'h0);
		idle(4);
		wr(6'h27, 8'hff, 2'h0);
		rd(6'h27, okv(8'h00));
		ext_val <= 8'h5a;
		idle(6);
		rd(6'h27, okv(8'haa));
		ext_val <= 8'hf0;
		idle(6);
		rd(6'h27, okv(8'haa));
		wr(6'h26, 8'h55, 2'h0);
		idle(2);
		check(okv({7'h0, port_irq}), okv(8'h00));
		wr(6'h26, 8'h02, 2'h0);
		idle(2);
		check(okv({7'h0, port_irq}), okv(8'h01));
		wr(6'h27, 8'h00, 2'h0);
		rd(6'h27, okv(8'haa));
		wr(6'h27, 8'h0a, 2'h0);
		rd(6'h27, okv(8'ha0));
		check(okv({7'h0, port_irq}), okv(8'h00));
		wr(6'h28, 8'h01, 2'h0);
		alt_pin_in <= 8'h81;
		idle(6);
		rd(6'h1f, okv(8'h01));
		wr(6'h29, 8'h01, 2'h0);
		idle(2);
		check(okv({7'h0, alt_port_irq}), okv(8'h01));
		wr(6'h1f, 8'h01, 2'h0);
		idle(2);
		check(okv({7'h0, alt_port_irq}), okv(8'h00));
		seed = xs(seed);
		spi_out <= seed[7:0];
		spi_oe <= 8'hff;
		wr(6'h2b, 8'h01, 2'h0);
		idle(4);
		check(okv(pin_oe), okv(8'h0f));
		check(okv({4'h0, pin_out[3:0]}), okv({4'h0, seed[3:0]}));
		check(okv(spi_in), okv({4'h0, seed[3:0]}));
		wr(6'h2b, 8'h02, 2'h0);
		idle(4);
		check(okv({pin_oe[7:4], pin_out[7:4]}), okv({4'hf, seed[7:4]}));
		check(okv(spi_in), okv({seed[7:4], 4'h0}));
		wr(6'h2a, 8'h03, 2'h0);
		idle(2);
		check(okv({6'h0, serial_periph_first_route, serial_periph_second_route}), okv(8'h03));
		wr(6'h2b, 8'h00, 2'h0);
		wr(6'h30, 8'h11, 2'h2);
		rd(6'h30, {2'h2, 32'h0});
		wr(6'h22, 8'hff, 2'h0);
		wr(6'h24, 8'hff, 2'h0);
		aresetn <= 1'b0;
		idle(2);
		check(okv(pin_oe | pin_pull_up | pin_pull_down), okv(8'h00));
		aresetn <= 1'b1;
		wr(6'h22, 8'hff, 2'h0);
		rd(6'h20, okv(8'h00));
		rd(6'h24, okv(8'h00));
		idle(2);
		close_out();
	end
endmodule // tb_top
bind phg_port phg_port_monitor #(.WIDTH(WIDTH)) u_phg_port_monitor (.aclk(aclk),
	.aresetn(aresetn), .pin_in(pin_in), .alt_pin_in(alt_pin_in), .pin_oe(pin_oe),
	.pin_weak_drive(pin_weak_drive), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
	.port_irq(port_irq), .alt_port_irq(alt_port_irq), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata));
`default_nettype wire
